// file: rtl/adc_conversion_sequencer.sv
// Function
// RULE1: clearing go mid-conversion aborts it at once
// RULE2: abort leaves both result registers untouched
// RULE3: abort waits two bit periods before acquiring
// RULE4: after that wait, acquisition restarts automatically
// RULE5: software must not set go with power-on
// RULE6: compare mode 1011 trigger starts powered conversion
// RULE7: every special trigger clears the selected timer
// RULE8: powered off, trigger only clears the timer
// RULE9: software selects channel and waits acquisition first
// RULE10: completion loads results, clears go, sets flag
// RULE11: a conversion lasts twelve bit periods
// RULE12: go reads set throughout, cleared at completion
// RULE13: clock select picks divider or RC source
// RULE14: done flag interrupts when enabled, with priority
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rc_clock_in,
  input  wire logic        comparator_in,
  input  wire logic        special_event_trigger,
  output logic             hold_connect,
  output logic [9:0]       sar_trial,
  output logic [2:0]       input_channel_select,
  output logic [3:0]       port_config,
  output logic             first_timer_clear,
  output logic             third_timer_clear,
  output logic             irq,
  output logic             irq_high_priority
);

  conv_control_s conv_control_reg;
  conv_config_s  conv_config_reg;
  logic [7:0]    result_high_byte;
  logic [7:0]    result_low_byte;
  logic [1:0]    irq_mask;
  logic          conv_done_flag;
  logic [3:0]    compare_two_mode_field;
  logic          timer_select;
  seq_state_e    state;
  seq_state_e    next_state;
  logic [5:0]    div_count;
  logic          tad_tick;
  logic [3:0]    tad_count;
  logic [9:0]    sar_value;
  logic [2:0]    rc_sync;
  logic          rc_level;
  logic          rc_level_prev;
  logic [2:0]    cmp_sync;
  logic          cmp_level;
  logic          status_seen;
  logic          done_event;
  logic          abort_event;
  logic          start_event;
  logic          sw_start;
  logic          hw_start;
  logic          trigger_routed;
  logic [2:0]    clock_select;
  logic [5:0]    div_limit;
  logic          setup_phase;
  logic          access_done;
  logic          wr_access;
  logic          rd_access;
  logic          addr_mapped;
  logic [31:0]   next_prdata;

  assign clock_select         = {conv_config_reg.clk_high, conv_control_reg.clk_low};
  assign input_channel_select = conv_control_reg.channel;
  assign port_config          = conv_config_reg.port_config;
  assign sar_trial            = sar_value;

  // APB: zero wait states, read data is captured in the setup cycle.
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable;
  assign wr_access   = access_done && pwrite;
  assign rd_access   = access_done && !pwrite;
  assign pready      = 1'b1;

  always_comb begin
    if (paddr == OFF_CONV_CONTROL) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFF_CONV_CONFIG) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFF_RESULT_HIGH) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFF_RESULT_LOW) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFF_IRQ_STATUS) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFF_IRQ_MASK) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFF_TRIG_SETUP) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  end

  assign pslverr = access_done && !addr_mapped;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == OFF_CONV_CONTROL) begin
      next_prdata[7:0] = {conv_control_reg.clk_low, conv_control_reg.channel,
                          state == S_CONVERT, 1'b0, conv_control_reg.power_on}; // RULE12
    end else if (paddr == OFF_CONV_CONFIG) begin
      next_prdata[7:0] = {conv_config_reg.right_justify, conv_config_reg.clk_high, 2'b00,
                          conv_config_reg.port_config};
    end else if (paddr == OFF_RESULT_HIGH) begin
      next_prdata[7:0] = result_high_byte;
    end else if (paddr == OFF_RESULT_LOW) begin
      next_prdata[7:0] = result_low_byte;
    end else if (paddr == OFF_IRQ_STATUS) begin
      next_prdata[IRQ_DONE_BIT] = conv_done_flag;
    end else if (paddr == OFF_IRQ_MASK) begin
      next_prdata[1:0] = irq_mask;
    end else if (paddr == OFF_TRIG_SETUP) begin
      next_prdata[4:0] = {timer_select, compare_two_mode_field};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0000_0000;
      status_seen <= 1'b0;
    end else if (setup_phase) begin
      prdata      <= next_prdata;
      status_seen <= (paddr == OFF_IRQ_STATUS) && conv_done_flag;
    end
  end

  // Control fields. The go bit itself lives in the state machine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_control_reg <= CONV_CONTROL_RESET;
    end else if (wr_access && paddr == OFF_CONV_CONTROL) begin
      conv_control_reg          <= pwdata[7:0];
      conv_control_reg.go       <= 1'b0;
      conv_control_reg.unused   <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_config_reg <= CONV_CONFIG_RESET;
    end else if (wr_access && paddr == OFF_CONV_CONFIG) begin
      conv_config_reg        <= pwdata[7:0];
      conv_config_reg.unused <= 2'b00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {timer_select, compare_two_mode_field} <= TRIG_SETUP_RESET;
      irq_mask                               <= 2'b00;
    end else if (wr_access && paddr == OFF_TRIG_SETUP) begin
      {timer_select, compare_two_mode_field} <= pwdata[4:0];
    end else if (wr_access && paddr == OFF_IRQ_MASK) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // Go handling: a start needs power already on before this write.
  assign sw_start    = wr_access && paddr == OFF_CONV_CONTROL && pwdata[2] &&
                       conv_control_reg.power_on && state == S_SAMPLE; // RULE5
  assign trigger_routed = special_event_trigger && compare_two_mode_field == COMPARE_MODE_SPECIAL;
  assign hw_start    = trigger_routed && conv_control_reg.power_on && state == S_SAMPLE; // RULE6 RULE8
  assign start_event = sw_start || hw_start;
  assign abort_event = state == S_CONVERT &&
                       ((wr_access && paddr == OFF_CONV_CONTROL && !pwdata[2]) ||
                        !conv_control_reg.power_on); // RULE1
  assign done_event  = state == S_CONVERT && tad_tick && tad_count == CONV_TAD_COUNT - 4'h1 &&
                       !abort_event; // RULE11

  // The timer is cleared even when the converter ignores the trigger.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_timer_clear <= 1'b0;
      third_timer_clear <= 1'b0;
    end else begin
      first_timer_clear <= trigger_routed && !timer_select; // RULE7 RULE8
      third_timer_clear <= trigger_routed && timer_select; // RULE7 RULE8
    end
  end

  // Pin inputs pass three flops; a level counts once the last two agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync   <= 3'b000;
      rc_level  <= 1'b0;
      cmp_sync  <= 3'b000;
      cmp_level <= 1'b0;
    end else begin
      rc_sync  <= {rc_sync[1:0], rc_clock_in};
      cmp_sync <= {cmp_sync[1:0], comparator_in};
      if (rc_sync[2] == rc_sync[1]) begin
        rc_level <= rc_sync[2];
      end
      if (cmp_sync[2] == cmp_sync[1]) begin
        cmp_level <= cmp_sync[2];
      end
    end
  end

  always_comb begin
    case (clock_select)
      CLK_DIV2:  div_limit = 6'h01;
      CLK_DIV4:  div_limit = 6'h03;
      CLK_DIV8:  div_limit = 6'h07;
      CLK_DIV16: div_limit = 6'h0f;
      CLK_DIV32: div_limit = 6'h1f;
      default:   div_limit = 6'h3f;
    endcase
  end

  // Bit-period enable from the divider or from the RC source edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count     <= 6'h00;
      rc_level_prev <= 1'b0;
      tad_tick      <= 1'b0;
    end else begin
      rc_level_prev <= rc_level;
      if (state == S_OFF || start_event || abort_event) begin
        div_count <= 6'h00;
        tad_tick  <= 1'b0;
      end else if (clock_select == CLK_RC) begin
        div_count <= 6'h00;
        tad_tick  <= rc_level && !rc_level_prev; // RULE13
      end else if (div_count >= div_limit) begin
        div_count <= 6'h00;
        tad_tick  <= 1'b1; // RULE13
      end else begin
        div_count <= div_count + 6'h01;
        tad_tick  <= 1'b0;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      S_OFF: begin
        if (conv_control_reg.power_on) begin
          next_state = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        if (!conv_control_reg.power_on) begin
          next_state = S_OFF;
        end else if (start_event) begin
          next_state = S_CONVERT;
        end
      end
      S_CONVERT: begin
        if (abort_event) begin
          next_state = S_HOLDOFF; // RULE1 RULE3
        end else if (done_event) begin
          next_state = S_SAMPLE; // RULE10 RULE12
        end
      end
      S_HOLDOFF: begin
        if (!conv_control_reg.power_on) begin
          next_state = S_OFF;
        end else if (tad_tick && tad_count == {2'b00, ABORT_TAD_COUNT} - 4'h1) begin
          next_state = S_SAMPLE; // RULE4
        end
      end
      default: next_state = S_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Bit-period counter and successive approximation register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tad_count <= 4'h0;
      sar_value <= 10'h000;
    end else if (next_state != state) begin
      tad_count <= 4'h0;
      sar_value <= (next_state == S_CONVERT) ? 10'h200 : 10'h000;
    end else if (tad_tick && (state == S_CONVERT || state == S_HOLDOFF)) begin
      tad_count <= tad_count + 4'h1;
      if (state == S_CONVERT && tad_count >= 4'h1 && tad_count <= 4'(RESULT_BITS)) begin
        sar_value[4'(RESULT_BITS) - tad_count] <= cmp_level;
        if (tad_count < 4'(RESULT_BITS)) begin
          sar_value[4'(RESULT_BITS) - 4'h1 - tad_count] <= 1'b1;
        end
      end
    end
  end

  // Results change only on completion or a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_byte <= RESULT_RESET;
      result_low_byte  <= RESULT_RESET;
    end else if (done_event) begin
      if (conv_config_reg.right_justify) begin
        result_high_byte <= {6'h00, sar_value[9:8]}; // RULE10
        result_low_byte  <= sar_value[7:0]; // RULE10
      end else begin
        result_high_byte <= sar_value[9:2]; // RULE10
        result_low_byte  <= {sar_value[1:0], 6'h00}; // RULE10
      end
    end else if (wr_access && paddr == OFF_RESULT_HIGH) begin
      result_high_byte <= pwdata[7:0]; // RULE2
    end else if (wr_access && paddr == OFF_RESULT_LOW) begin
      result_low_byte <= pwdata[7:0]; // RULE2
    end
  end

  // Done flag: a new completion wins over the read that clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_flag <= 1'b0;
    end else if (done_event) begin
      conv_done_flag <= 1'b1; // RULE10 RULE14
    end else if (rd_access && paddr == OFF_IRQ_STATUS && status_seen) begin
      conv_done_flag <= 1'b0; // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_connect      <= 1'b0;
      irq               <= 1'b0;
      irq_high_priority <= 1'b0;
    end else begin
      hold_connect      <= next_state == S_SAMPLE; // RULE10
      irq               <= (conv_done_flag || done_event) && irq_mask[IRQ_DONE_BIT]; // RULE14
      irq_high_priority <= irq_mask[IRQ_PRIORITY_BIT]; // RULE14
    end
  end

endmodule : adc_conversion_sequencer

// file: rtl/adc_seq_pkg.sv
package adc_seq_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] OFF_CONV_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONV_CONFIG  = 8'h04;
  localparam logic [7:0] OFF_RESULT_HIGH  = 8'h08;
  localparam logic [7:0] OFF_RESULT_LOW   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h14;
  localparam logic [7:0] OFF_TRIG_SETUP   = 8'h18;

  localparam logic [7:0] CONV_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONV_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] RESULT_RESET       = 8'h00;
  localparam logic [4:0] TRIG_SETUP_RESET   = 5'h00;

  // Compare unit two mode that routes its special event to the converter.
  localparam logic [3:0] COMPARE_MODE_SPECIAL = 4'hb;

  // Clock select codes (three bits: high bit from config, low two from control).
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [2:0] CLK_RC    = 3'h3;

  // Bit periods per conversion and after an abort.
  localparam logic [3:0] CONV_TAD_COUNT  = 4'hc;
  localparam logic [1:0] ABORT_TAD_COUNT = 2'h2;
  localparam int         RESULT_BITS     = 10;

  // Interrupt status and mask bit positions.
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_PRIORITY_BIT = 1;

  typedef struct packed {
    logic [1:0] clk_low;
    logic [2:0] channel;
    logic       go;
    logic       unused;
    logic       power_on;
  } conv_control_s;

  typedef struct packed {
    logic       right_justify;
    logic       clk_high;
    logic [1:0] unused;
    logic [3:0] port_config;
  } conv_config_s;

  typedef enum logic [3:0] {
    S_OFF     = 4'b0001,
    S_SAMPLE  = 4'b0010,
    S_CONVERT = 4'b0100,
    S_HOLDOFF = 4'b1000
  } seq_state_e;

endpackage : adc_seq_pkg

// file: dv/adc_seq_chk.sv
`timescale 1ns/1ps

module adc_seq_chk
  import adc_seq_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rc_clock_in,
  input wire logic        comparator_in,
  input wire logic        special_event_trigger,
  input wire logic        hold_connect,
  input wire logic [9:0]  sar_trial,
  input wire logic [2:0]  input_channel_select,
  input wire logic [3:0]  port_config,
  input wire logic        first_timer_clear,
  input wire logic        third_timer_clear,
  input wire logic        irq,
  input wire logic        irq_high_priority
);
  logic       pw_on;
  logic       en_q;
  logic       busy;
  logic       hold_q;
  logic [4:0] trig_q;
  wire        wr        = psel && penable && pwrite;
  wire        wr_ctrl   = wr && paddr == OFF_CONV_CONTROL;
  wire        wr_mask   = wr && paddr == OFF_IRQ_MASK;
  wire        rd_status = psel && penable && !pwrite && paddr == OFF_IRQ_STATUS;
  wire        routed    = special_event_trigger && trig_q[3:0] == COMPARE_MODE_SPECIAL;

  // Shadows of the control, mask and trigger setup writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_on  <= 1'b0;
      en_q   <= 1'b0;
      trig_q <= 5'h00;
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_connect;
      if (wr_ctrl) pw_on <= pwdata[0];
      if (wr_mask) en_q <= pwdata[IRQ_DONE_BIT];
      if (wr && paddr == OFF_TRIG_SETUP) trig_q <= pwdata[4:0];
    end
  end

  // Marks a conversion that is running and has not been aborted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy <= 1'b0;
    else if (wr_ctrl && (!pwdata[2] || !pwdata[0])) busy <= 1'b0;
    else if (hold_q && !hold_connect && pw_on) busy <= 1'b1;
    else if (hold_connect) busy <= 1'b0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_slverr; psel && penable |-> pslverr == (paddr[1:0] != 2'b00 || paddr > OFF_TRIG_SETUP); endproperty
  a_slverr: assert property (p_slverr) else $error("slave error does not match decode");
  property p_start; wr_ctrl && pwdata[2] && pwdata[0] && pw_on && hold_connect |=> !hold_connect; endproperty
  a_start: assert property (p_start) else $error("go write did not start");
  property p_trig_start; routed && pw_on && hold_connect && !wr_ctrl |=> !hold_connect; endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
  property p_trig_off; special_event_trigger && !pw_on && !wr_ctrl |=> !hold_connect [*3]; endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger acted while off");
  property p_abort; wr_ctrl && !pwdata[2] && busy |=> !hold_connect [*2]; endproperty
  a_abort: assert property (p_abort) else $error("abort skipped the hold off");
  property p_done_irq; $rose(hold_connect) && busy && en_q |-> ##[0:2] irq; endproperty
  a_done_irq: assert property (p_done_irq) else $error("no irq after done");
  property p_irq_off; !en_q && !$past(en_q) |-> !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_irq_hold; irq && en_q && !rd_status && !$past(rd_status) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without read");
  property p_irq_clear; rd_status && irq |-> ##[1:2] !irq; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read left irq");
  property p_timer; routed |=> first_timer_clear == !trig_q[4] && third_timer_clear == trig_q[4]; endproperty
  a_timer: assert property (p_timer) else $error("timer clear wrong");
  property p_timer_quiet; !routed |=> !first_timer_clear && !third_timer_clear; endproperty
  a_timer_quiet: assert property (p_timer_quiet) else $error("spurious timer clear");
endmodule : adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .rc_clock_in(rc_clock_in), .comparator_in(comparator_in),
  .special_event_trigger(special_event_trigger), .hold_connect(hold_connect), .sar_trial(sar_trial),
  .input_channel_select(input_channel_select), .port_config(port_config), .first_timer_clear(first_timer_clear),
  .third_timer_clear(third_timer_clear), .irq(irq), .irq_high_priority(irq_high_priority));

// file: dv/test_adc_conversion_sequencer.sv
`timescale 1ns/1ps

module test_adc_conversion_sequencer
  import adc_seq_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, rc_clock_in, comparator_in, special_event_trigger;
  logic        pready, pslverr, rerr, hold_connect, first_timer_clear, third_timer_clear, irq, irq_high_priority;
  logic        seen1, seen3, cmp_high;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0]  input_channel_select;
  logic [3:0]  port_config;
  logic [9:0]  sar_trial;
  int          n_mismatch, checks, n;
  localparam logic [2:0] CODES [7] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_DIV16, CLK_DIV32, CLK_DIV64, CLK_RC};
  // The RC source below toggles every 50 ns, so one bit period is ten clocks.
  localparam int         DIVS  [7] = '{2, 4, 8, 16, 32, 64, 10};

  adc_conversion_sequencer u_adc_conversion_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rc_clock_in(rc_clock_in), .comparator_in(comparator_in),
    .special_event_trigger(special_event_trigger), .hold_connect(hold_connect), .sar_trial(sar_trial),
    .input_channel_select(input_channel_select), .port_config(port_config),
    .first_timer_clear(first_timer_clear), .third_timer_clear(third_timer_clear), .irq(irq),
    .irq_high_priority(irq_high_priority));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    rc_clock_in = 1'b0;
    forever #50 rc_clock_in = ~rc_clock_in;
  end

  // While cmp_high is set the comparator reads high, so a conversion resolves to all ones.
  always @(posedge pclk) comparator_in <= cmp_high | ~comparator_in;

  task summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
    apb(1'b0, addr, 32'h0);
    chk(rdata, exp, what);
  endtask : rd

  task pulse(input logic [7:0] setup);
    apb(1'b1, OFF_TRIG_SETUP, {24'h0, setup});
    @(posedge pclk);
    special_event_trigger <= 1'b1;
    seen1 = 1'b0;
    seen3 = 1'b0;
    @(posedge pclk);
    special_event_trigger <= 1'b0;
    repeat (3) begin
      @(posedge pclk);
      seen1 = seen1 | first_timer_clear;
      seen3 = seen3 | third_timer_clear;
    end
  endtask : pulse

  task wait_hold(input int lo, input int hi, input string what);
    n = 0;
    while (hold_connect !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1, what);
  endtask : wait_hold

  task start(input logic [7:0] ctrl);
    apb(1'b1, OFF_CONV_CONTROL, {24'h0, ctrl});
    apb(1'b1, OFF_CONV_CONTROL, {24'h0, ctrl | 8'h04});
    @(posedge pclk);
    chk(32'(hold_connect), 32'h0, "capacitor still held");
    chk({22'h0, sar_trial}, 32'h200, "first trial code");
  endtask : start

  initial begin
    {psel, penable, pwrite, paddr, pwdata, comparator_in, special_event_trigger, presetn, cmp_high} = '0;
    {n_mismatch, checks} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4) rd(8'(a), 32'h0, "reset value");
    apb(1'b1, 8'h1c, 32'hff);
    chk(32'(rerr), 32'h1, "unmapped write");
    rd(8'h40, 32'h0, "unmapped read");
    chk(32'(rerr), 32'h1, "unmapped read error");
    apb(1'b1, OFF_RESULT_HIGH, 32'ha5);
    apb(1'b1, OFF_RESULT_LOW, 32'hc3);
    rd(OFF_RESULT_HIGH, 32'ha5, "result high rw");
    rd(OFF_RESULT_LOW, 32'hc3, "result low rw");
    apb(1'b1, OFF_IRQ_MASK, 32'h3);
    rd(OFF_IRQ_MASK, 32'h3, "mask");
    chk(32'(irq_high_priority), 32'h1, "priority");
    apb(1'b1, OFF_CONV_CONTROL, 32'h01);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, OFF_CONV_CONFIG, {24'h0, 1'b0, CODES[i][2], 2'h0, 4'(i)});
      start({CODES[i][1:0], CODES[i], 3'b001});
      rd(OFF_CONV_CONTROL, {24'h0, CODES[i][1:0], CODES[i], 3'b101}, "go set");
      chk({29'h0, input_channel_select}, {29'h0, CODES[i]}, "channel");
      chk({28'h0, port_config}, 32'(i), "port config");
      wait_hold(11 * DIVS[i] - 4, 12 * DIVS[i] + 12, "conversion length");
      rd(OFF_CONV_CONTROL, {24'h0, CODES[i][1:0], CODES[i], 3'b001}, "go cleared");
      chk(32'(irq), 32'h1, "irq");
      rd(OFF_IRQ_STATUS, 32'h1, "done flag");
      rd(OFF_IRQ_STATUS, 32'h0, "flag read clear");
      chk(32'(irq), 32'h0, "irq cleared");
    end
    apb(1'b1, OFF_RESULT_HIGH, 32'h5a);
    apb(1'b1, OFF_RESULT_LOW, 32'h3c);
    apb(1'b1, OFF_CONV_CONFIG, 32'h40);
    start(8'h81);
    repeat (60) @(posedge pclk);
    apb(1'b1, OFF_CONV_CONTROL, 32'h81);
    wait_hold(125, 135, "abort hold off");
    rd(OFF_RESULT_HIGH, 32'h5a, "result high kept");
    rd(OFF_RESULT_LOW, 32'h3c, "result low kept");
    rd(OFF_IRQ_STATUS, 32'h0, "no done on abort");
    apb(1'b1, OFF_CONV_CONTROL, 32'h80);
    pulse(8'h0b);
    chk({31'h0, seen1, seen3}, 32'h2, "timer clear while off");
    rd(OFF_CONV_CONTROL, 32'h80, "trigger ignored off");
    cmp_high <= 1'b1;
    apb(1'b1, OFF_CONV_CONTROL, 32'h81);
    repeat (4) @(posedge pclk);
    pulse(8'h1b);
    chk({31'h0, seen1, seen3}, 32'h1, "third timer clear");
    rd(OFF_CONV_CONTROL, 32'h85, "trigger sets go");
    wait_hold(700, 780, "triggered conversion");
    rd(OFF_IRQ_STATUS, 32'h1, "triggered done");
    rd(OFF_RESULT_HIGH, 32'hff, "result high loaded");
    rd(OFF_RESULT_LOW, 32'hc0, "result low loaded");
    pulse(8'h0a);
    chk({31'h0, seen1, seen3}, 32'h0, "other mode");
    rd(OFF_CONV_CONTROL, 32'h81, "other mode no start");
    apb(1'b1, OFF_CONV_CONTROL, 32'h00);
    apb(1'b1, OFF_CONV_CONTROL, 32'h05);
    rd(OFF_CONV_CONTROL, 32'h01, "go with power on");
    summarize();
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("ERROR at %0t: timeout", $time);
    summarize();
  end
endmodule : test_adc_conversion_sequencer
